/* File: rtl/slgo_pkg.sv */
// constants for the output gain and offset conditioning stage
package slgo_pkg;
  localparam int          SAMPLE_W      = 18;
  localparam int          REG_W         = 16;
  localparam int          TBL_DEPTH     = 32;
  localparam int          TBL_IDX_W     = 5;
  localparam int          IDX_W         = 8;
  // printed register indexes; the byte address is four times the index
  localparam logic [7:0]  IDX_TAB_SHIFT = 8'hD2;
  localparam logic [7:0]  IDX_TBL_FIRST = 8'hD3;
  localparam logic [7:0]  IDX_TBL_LAST  = 8'hF2;
  localparam logic [7:0]  IDX_GAIN_A    = 8'hF3;
  localparam logic [7:0]  IDX_GAIN_B    = 8'hF4;
  localparam logic [7:0]  IDX_OFF_I0    = 8'hF5;
  localparam logic [7:0]  IDX_OFF_Q0    = 8'hF6;
  localparam logic [7:0]  IDX_OFF_I1    = 8'hF7;
  localparam logic [7:0]  IDX_OFF_Q1    = 8'hF8;
  localparam logic [7:0]  IDX_MODE      = 8'hF9;
  localparam logic [7:0]  IDX_STATUS    = 8'hFA;
  // reset values
  localparam logic [15:0] RST_TAB_SHIFT = 16'hFFFF;
  localparam logic [15:0] RST_ZERO      = 16'h0000;
  // field layout
  localparam int          SHIFT_FLD_W   = 4;
  localparam logic [5:0]  SHIFT_BIAS    = 6'h11;
  localparam int          GAIN_SIGN_BIT = 15;
  localparam int          GAIN_MAG_W    = 15;
  localparam int          GAIN_FRAC     = 13;
  localparam logic [15:0] GAIN_UNITY    = 16'h2000;
  localparam int          OFF_ALIGN     = 2;
  localparam int          MODE_TWO_CH   = 2;
  localparam int          STAT_SAT      = 0;
  // interpolator mode codes
  localparam logic [1:0]  INTERP_CPLX   = 2'h0;
  localparam logic [1:0]  INTERP_REAL2  = 2'h1;
  // axi answers
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;
  localparam int          PIPE_LAT      = 2;
endpackage

/* File: rtl/slgo_top.sv */
// output gain, dc offset and limiter table registers with an axi4-lite slave
// What this block does
// - table shift field is low four bits, 0..15; shift applied is field plus 17
// - inverse gain table entries 0..31 ascend from 1.0 up to ratio g
// - every inverse gain entry is a full unsigned 16-bit coefficient
// - gain magnitude bits 14..0, 0x2000 is unity, boost up to nearly 4.0
// - gain bit 15 is sign; negative gain inverts port phase
// - zero gain register drives zero samples on that port
// - first gain scales port A, second gain scales port B independently
// - offsets are signed 16-bit, added to upper 16 bits of 18-bit samples
// - channel 0 offsets apply to port A, sole offsets in one-channel mode
// - channel 1 offsets apply to port B in two-channel mode
// - in real output modes each channel's I offset offsets its real samples
// - reset: table shift 0xFFFF, table, gains and offsets zero
// - gain and offset stay in the sample path even with limiter bypassed
// - interpolator mode 00 complex, 01 and 1x real output
`timescale 1ns/1ps
module slgo_top
  import slgo_pkg::*;
(
  // clock and reset
  input  wire logic                        aclk,
  input  wire logic                        aresetn,
  // axi4-lite write address and data
  input  wire logic [9:0]                  s_axi_awaddr,
  input  wire logic                        s_axi_awvalid,
  output logic                             s_axi_awready,
  input  wire logic [31:0]                 s_axi_wdata,
  input  wire logic [3:0]                  s_axi_wstrb,
  input  wire logic                        s_axi_wvalid,
  output logic                             s_axi_wready,
  output logic [1:0]                       s_axi_bresp,
  output logic                             s_axi_bvalid,
  input  wire logic                        s_axi_bready,
  // axi4-lite read
  input  wire logic [9:0]                  s_axi_araddr,
  input  wire logic                        s_axi_arvalid,
  output logic                             s_axi_arready,
  output logic [31:0]                      s_axi_rdata,
  output logic [1:0]                       s_axi_rresp,
  output logic                             s_axi_rvalid,
  input  wire logic                        s_axi_rready,
  // samples in from the interpolator, limiter bypassed or not
  input  wire logic                        in_valid,
  input  wire logic signed [SAMPLE_W-1:0]  in_a_i,
  input  wire logic signed [SAMPLE_W-1:0]  in_a_q,
  input  wire logic signed [SAMPLE_W-1:0]  in_b_i,
  input  wire logic signed [SAMPLE_W-1:0]  in_b_q,
  // samples out to the converter
  output logic                             out_valid,
  output logic signed [SAMPLE_W-1:0]       out_a_i,
  output logic signed [SAMPLE_W-1:0]       out_a_q,
  output logic signed [SAMPLE_W-1:0]       out_b_i,
  output logic signed [SAMPLE_W-1:0]       out_b_q,
  // limiter table lookup port
  input  wire logic [TBL_IDX_W-1:0]        tbl_index,
  output logic [REG_W-1:0]                 tbl_coef,
  output logic [5:0]                       limiter_shift_n
);
  import slgo_pkg::*;

  localparam logic signed [SAMPLE_W-1:0] SMAX = {1'b0, {(SAMPLE_W-1){1'b1}}};
  localparam logic signed [SAMPLE_W-1:0] SMIN = {1'b1, {(SAMPLE_W-1){1'b0}}};

  logic [REG_W-1:0] tab_shift_q;
  logic [REG_W-1:0] inv_gain_q [TBL_DEPTH];
  logic [REG_W-1:0] gain_a_q;
  logic [REG_W-1:0] gain_b_q;
  logic [REG_W-1:0] off_i0_q;
  logic [REG_W-1:0] off_q0_q;
  logic [REG_W-1:0] off_i1_q;
  logic [REG_W-1:0] off_q1_q;
  logic [2:0]       mode_q;
  logic             sat_q;
  logic             wr_go;
  logic [IDX_W-1:0] ar_idx;

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic [REG_W-1:0] merge(input logic [REG_W-1:0] old, input logic [31:0] d,
                                             input logic [3:0] be);
    merge = old;
    if (be[0]) merge[7:0] = d[7:0];
    if (be[1]) merge[15:8] = d[15:8];
  endfunction

  // sign-magnitude gain, 13 fractional bits, clipped to the sample range
  function automatic logic signed [SAMPLE_W-1:0] scale(input logic signed [SAMPLE_W-1:0] s,
                                                       input logic [REG_W-1:0] g);
    logic signed [SAMPLE_W+GAIN_MAG_W:0] p;
    p = '0;
    p = s * $signed({1'b0, g[GAIN_MAG_W-1:0]});
    p = p >>> GAIN_FRAC;
    if (g[GAIN_SIGN_BIT]) p = -p;
    if (p > SMAX) scale = SMAX;
    else if (p < SMIN) scale = SMIN;
    else scale = p[SAMPLE_W-1:0];
  endfunction

  // offset lines up with the top 16 of the 18 sample bits
  function automatic logic signed [SAMPLE_W-1:0] offs(input logic signed [SAMPLE_W-1:0] s,
                                                      input logic [REG_W-1:0] o);
    logic signed [SAMPLE_W:0] t;
    t = '0;
    t = s + $signed({o, {OFF_ALIGN{1'b0}}});
    if (t > SMAX) offs = SMAX;
    else if (t < SMIN) offs = SMIN;
    else offs = t[SAMPLE_W-1:0];
  endfunction

  function automatic logic clips(input logic signed [SAMPLE_W-1:0] s, input logic [REG_W-1:0] g,
                                 input logic [REG_W-1:0] o);
    logic signed [SAMPLE_W+GAIN_MAG_W:0] p;
    logic signed [SAMPLE_W:0]            t;
    p = s * $signed({1'b0, g[GAIN_MAG_W-1:0]});
    p = p >>> GAIN_FRAC;
    t = s + $signed({o, {OFF_ALIGN{1'b0}}});
    clips = (p > SMAX) || (-p > SMAX) || (t > SMAX) || (t < SMIN);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // axi4-lite write: both channels are taken together, after the master offers both

  assign wr_go = s_axi_awready && s_axi_awvalid && s_axi_wvalid;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
    end
    else if (wr_go)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b1;
      s_axi_bresp   <= (s_axi_awaddr[9:2] >= IDX_TAB_SHIFT && s_axi_awaddr[9:2] <= IDX_STATUS)
                       ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_bvalid)
    begin
      if (s_axi_bready) s_axi_bvalid <= 1'b0;
    end
    else if (s_axi_awvalid && s_axi_wvalid)
    begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
    end
  end

  // register stores; wstrb lanes 2 and 3 have no bits behind them
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      tab_shift_q <= RST_TAB_SHIFT;
      gain_a_q    <= RST_ZERO;
      gain_b_q    <= RST_ZERO;
      off_i0_q    <= RST_ZERO;
      off_q0_q    <= RST_ZERO;
      off_i1_q    <= RST_ZERO;
      off_q1_q    <= RST_ZERO;
      mode_q      <= '0;
      for (int k = 0; k < TBL_DEPTH; k++) inv_gain_q[k] <= RST_ZERO;
    end
    else if (wr_go)
    begin
      if (s_axi_awaddr[9:2] == IDX_TAB_SHIFT)
        tab_shift_q <= merge(tab_shift_q, s_axi_wdata, s_axi_wstrb);
      else if (s_axi_awaddr[9:2] >= IDX_TBL_FIRST && s_axi_awaddr[9:2] <= IDX_TBL_LAST)
        inv_gain_q[TBL_IDX_W'(s_axi_awaddr[9:2] - IDX_TBL_FIRST)] <=
          merge(inv_gain_q[TBL_IDX_W'(s_axi_awaddr[9:2] - IDX_TBL_FIRST)], s_axi_wdata, s_axi_wstrb);
      else if (s_axi_awaddr[9:2] == IDX_GAIN_A)
        gain_a_q <= merge(gain_a_q, s_axi_wdata, s_axi_wstrb);
      else if (s_axi_awaddr[9:2] == IDX_GAIN_B)
        gain_b_q <= merge(gain_b_q, s_axi_wdata, s_axi_wstrb);
      else if (s_axi_awaddr[9:2] == IDX_OFF_I0)
        off_i0_q <= merge(off_i0_q, s_axi_wdata, s_axi_wstrb);
      else if (s_axi_awaddr[9:2] == IDX_OFF_Q0)
        off_q0_q <= merge(off_q0_q, s_axi_wdata, s_axi_wstrb);
      else if (s_axi_awaddr[9:2] == IDX_OFF_I1)
        off_i1_q <= merge(off_i1_q, s_axi_wdata, s_axi_wstrb);
      else if (s_axi_awaddr[9:2] == IDX_OFF_Q1)
        off_q1_q <= merge(off_q1_q, s_axi_wdata, s_axi_wstrb);
      else if (s_axi_awaddr[9:2] == IDX_MODE && s_axi_wstrb[0])
        mode_q <= s_axi_wdata[2:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // axi4-lite read

  assign ar_idx = s_axi_araddr[9:2];

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= RESP_OKAY;
    end
    else if (s_axi_arready && s_axi_arvalid)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= RESP_OKAY;
      s_axi_rdata   <= '0;
      if (ar_idx == IDX_TAB_SHIFT) s_axi_rdata[15:0] <= tab_shift_q;
      else if (ar_idx >= IDX_TBL_FIRST && ar_idx <= IDX_TBL_LAST)
        s_axi_rdata[15:0] <= inv_gain_q[TBL_IDX_W'(ar_idx - IDX_TBL_FIRST)];
      else if (ar_idx == IDX_GAIN_A) s_axi_rdata[15:0] <= gain_a_q;
      else if (ar_idx == IDX_GAIN_B) s_axi_rdata[15:0] <= gain_b_q;
      else if (ar_idx == IDX_OFF_I0) s_axi_rdata[15:0] <= off_i0_q;
      else if (ar_idx == IDX_OFF_Q0) s_axi_rdata[15:0] <= off_q0_q;
      else if (ar_idx == IDX_OFF_I1) s_axi_rdata[15:0] <= off_i1_q;
      else if (ar_idx == IDX_OFF_Q1) s_axi_rdata[15:0] <= off_q1_q;
      else if (ar_idx == IDX_MODE) s_axi_rdata[2:0] <= mode_q;
      else if (ar_idx == IDX_STATUS) s_axi_rdata[STAT_SAT] <= sat_q;
      else s_axi_rresp <= RESP_SLVERR;
    end
    else if (s_axi_rvalid)
    begin
      if (s_axi_rready) s_axi_rvalid <= 1'b0;
    end
    else if (s_axi_arvalid)
      s_axi_arready <= 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // limiter table lookup and shift amount

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      tbl_coef        <= '0;
      limiter_shift_n <= '0;
    end
    else
    begin
      tbl_coef        <= inv_gain_q[tbl_index];
      limiter_shift_n <= 6'(tab_shift_q[SHIFT_FLD_W-1:0]) + SHIFT_BIAS;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sample path: stage 1 gain, stage 2 offset; always in line, limiter or not

  logic                       s1_valid_q;
  logic                       s1_zero_a_q;
  logic                       s1_zero_b_q;
  logic signed [SAMPLE_W-1:0] s1_a_i_q;
  logic signed [SAMPLE_W-1:0] s1_a_q_q;
  logic signed [SAMPLE_W-1:0] s1_b_i_q;
  logic signed [SAMPLE_W-1:0] s1_b_q_q;
  logic                       real_mode;
  logic [REG_W-1:0]           ob_i;
  logic [REG_W-1:0]           ob_q;
  logic [REG_W-1:0]           off_a_quad;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s1_valid_q  <= 1'b0;
      s1_zero_a_q <= 1'b1;
      s1_zero_b_q <= 1'b1;
      s1_a_i_q    <= '0;
      s1_a_q_q    <= '0;
      s1_b_i_q    <= '0;
      s1_b_q_q    <= '0;
    end
    else
    begin
      s1_valid_q  <= in_valid;
      s1_zero_a_q <= (gain_a_q == RST_ZERO);
      s1_zero_b_q <= (gain_b_q == RST_ZERO);
      s1_a_i_q    <= scale(in_a_i, gain_a_q);
      s1_a_q_q    <= scale(in_a_q, gain_a_q);
      s1_b_i_q    <= scale(in_b_i, gain_b_q);
      s1_b_q_q    <= scale(in_b_q, gain_b_q);
    end
  end

  // real modes carry real samples on both legs, so the I offset serves both
  assign real_mode = (mode_q[1:0] != INTERP_CPLX);
  assign off_a_quad = real_mode ? off_i0_q : off_q0_q;
  assign ob_i      = mode_q[MODE_TWO_CH] ? off_i1_q : off_i0_q;
  assign ob_q      = real_mode ? ob_i : (mode_q[MODE_TWO_CH] ? off_q1_q : off_q0_q);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      out_valid <= 1'b0;
      out_a_i   <= '0;
      out_a_q   <= '0;
      out_b_i   <= '0;
      out_b_q   <= '0;
    end
    else
    begin
      out_valid <= s1_valid_q;
      // a zeroed gain mutes the port outright, offsets included
      out_a_i   <= s1_zero_a_q ? '0 : offs(s1_a_i_q, off_i0_q);
      out_a_q   <= s1_zero_a_q ? '0 : offs(s1_a_q_q, off_a_quad);
      out_b_i   <= s1_zero_b_q ? '0 : offs(s1_b_i_q, ob_i);
      out_b_q   <= s1_zero_b_q ? '0 : offs(s1_b_q_q, ob_q);
    end
  end

  // sticky clip flag; write one to clear, a clip in the same cycle wins
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      sat_q <= 1'b0;
    else if (in_valid && (clips(in_a_i, gain_a_q, RST_ZERO) || clips(in_b_i, gain_b_q, RST_ZERO)))
      sat_q <= 1'b1;
    else if (wr_go && s_axi_awaddr[9:2] == IDX_STATUS && s_axi_wstrb[0] && s_axi_wdata[STAT_SAT])
      sat_q <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence unity_a;
    in_valid && gain_a_q == GAIN_UNITY && off_i0_q == RST_ZERO ##1 off_i0_q == RST_ZERO;
  endsequence

  AST_LATENCY: assert property (in_valid |-> ##2 out_valid)
    else $error("sample valid lost in pipe");
  AST_ZERO_GAIN: assert property (in_valid && gain_a_q == RST_ZERO |-> ##2 out_a_i == 0 && out_a_q == 0)
    else $error("zero gain did not mute port a");
  AST_UNITY: assert property (unity_a |-> ##1 out_a_i == $past(in_a_i, 2))
    else $error("unity gain altered port a");
  AST_NEGATE: assert property (in_valid && gain_a_q == 16'hA000 && in_a_i != SMIN ##1 off_i0_q == RST_ZERO
                               |=> out_a_i == -$past(in_a_i, 2))
    else $error("negative gain did not invert");
  AST_BOOST_SAT: assert property (in_valid && gain_b_q == 16'h7FFF && in_b_i == SMAX ##1 !ob_i[REG_W-1]
                                  |=> out_b_i == SMAX)
    else $error("boost wrapped instead of clipping");
  AST_CH1_OFFSET: assert property (in_valid && gain_b_q == GAIN_UNITY && in_b_i == 0 ##1
                                   mode_q[MODE_TWO_CH] && $stable(off_i1_q)
                                   |=> out_b_i == $signed({$past(off_i1_q), 2'b00}))
    else $error("channel 1 offset not on port b");
  AST_SHIFT: assert property (aresetn |=> limiter_shift_n == 6'($past(tab_shift_q[3:0])) + SHIFT_BIAS)
    else $error("limiter shift wrong");
  AST_TABLE: assert property (aresetn |=> tbl_coef == inv_gain_q[$past(tbl_index)] || $past(wr_go))
    else $error("table lookup wrong");
  AST_BRESP: assert property (wr_go |=> s_axi_bvalid && !s_axi_awready)
    else $error("write answer missing");
endmodule

/* File: verif/slgo_dac_sink.sv */
// behavioural converter sink that takes every sample the stage emits
`timescale 1ns/1ps
module slgo_dac_sink
  import slgo_pkg::*;
(
  // clock and reset
  input  wire logic                        aclk,
  input  wire logic                        aresetn,
  // samples from the stage
  input  wire logic                        smp_valid,
  input  wire logic signed [SAMPLE_W-1:0]  a_i,
  input  wire logic signed [SAMPLE_W-1:0]  b_i,
  // tally of accepted samples
  output int                               n_taken,
  output logic [2*SAMPLE_W-1:0]            last_i
);
  // a converter never stalls, so every valid cycle is one sample taken
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      n_taken <= 0;
    else if (smp_valid === 1'b1)
      n_taken <= n_taken + 1;
  end

  always_ff @(posedge aclk)
  begin
    if (smp_valid === 1'b1)
      last_i <= {a_i, b_i};
  end
endmodule

/* File: verif/tb.sv */
// self-checking bench for the output gain and offset stage
`timescale 1ns/1ps
module tb;
  import slgo_pkg::*;
  logic              aclk, aresetn;
  logic [9:0]        s_axi_awaddr, s_axi_araddr;
  logic [31:0]       s_axi_wdata, s_axi_rdata;
  logic [3:0]        s_axi_wstrb;
  logic [1:0]        s_axi_bresp, s_axi_rresp, rsp;
  logic              s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic              s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic              in_valid, out_valid;
  logic [17:0]       in_a_i, in_a_q, in_b_i, in_b_q, out_a_i, out_a_q, out_b_i, out_b_q;
  logic [4:0]        tbl_index;
  logic [15:0]       tbl_coef, gain[2], off[4], tv[32];
  logic [5:0]        limiter_shift_n;
  logic [2:0]        mode;
  logic [31:0]       rd_d;
  logic [71:0]       q[$];
  int                n_fail, n_compared, seed, pushed, n_taken;

  slgo_top i_slgo_top (.*);
  slgo_dac_sink i_slgo_dac_sink (.aclk(aclk), .aresetn(aresetn), .smp_valid(out_valid), .a_i(out_a_i),
    .b_i(out_b_i), .n_taken(n_taken), .last_i());

  initial
  begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic conclude;
    if (n_fail == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [71:0] seen, input logic [71:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // upper half of wdata is junk on purpose; the slave must drop it
  task automatic wr(input logic [7:0] idx, input logic [15:0] d, output logic [1:0] resp);
    int k;
    @(posedge aclk);
    s_axi_awaddr  <= {idx, 2'b00};
    s_axi_awvalid <= 1'b1;
    s_axi_wdata   <= {16'hFFFF, d};
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    for (k = 0; k < 200; k++)
    begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1)
      begin
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
        return;
      end
    end
    n_fail++;
    conclude();
  endtask

  task automatic rd(input logic [7:0] idx, output logic [31:0] d, output logic [1:0] resp);
    int k;
    @(posedge aclk);
    s_axi_araddr  <= {idx, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    for (k = 0; k < 200; k++)
    begin
      @(posedge aclk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1)
      begin
        d = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
        return;
      end
    end
    n_fail++;
    conclude();
  endtask

  task automatic setr(input logic [7:0] idx, input logic [15:0] d);
    wr(idx, d, rsp);
    chk("wresp", rsp, RESP_OKAY);
    rd(idx, rd_d, rsp);
    chk("readback", rd_d, {16'h0000, d});
  endtask

  ////////////////////////////////////////////////////////////////////////////
  function automatic longint clip(input longint p);
    return (p > 131071) ? 131071 : ((p < -131072) ? -131072 : p);
  endfunction

  function automatic logic [17:0] mdl(input logic [17:0] s, input logic [15:0] g, input logic [15:0] o);
    longint p;
    if (g == 16'h0000)
      return 18'h00000;
    p = (longint'($signed(s)) * longint'(g[14:0])) >>> 13;
    if (g[15])
      p = -p;
    return 18'(clip(clip(p) + longint'($signed(o)) * 4));
  endfunction

  // offset pick: channel 1 only for port b in two-channel mode, i leg reused in real modes
  function automatic logic [15:0] ofs(input int port, input int leg);
    return off[((port == 1 && mode[2]) ? 2 : 0) + ((leg == 1 && mode[1:0] == 2'h0) ? 1 : 0)];
  endfunction

  task automatic stream(input int n);
    logic [17:0] s[4];
    for (int k = 0; k < n; k++)
    begin
      @(posedge aclk);
      foreach (s[j])
      begin
        s[j] = 18'($random(seed));
        // edge values that the clip and offset checks need to see now and then
        if (s[j][17:15] == 3'h3) s[j] = 18'h1FFFF;
        if (s[j][17:15] == 3'h4) s[j] = 18'h00000;
      end
      in_valid <= ($random(seed) % 4) != 0;
      {in_a_i, in_a_q, in_b_i, in_b_q} <= {s[0], s[1], s[2], s[3]};
      #1;
      if (in_valid)
      begin
        q.push_back({mdl(s[0], gain[0], ofs(0, 0)), mdl(s[1], gain[0], ofs(0, 1)),
                     mdl(s[2], gain[1], ofs(1, 0)), mdl(s[3], gain[1], ofs(1, 1))});
        pushed++;
      end
    end
    @(posedge aclk);
    in_valid <= 1'b0;
    repeat (4) @(posedge aclk);
  endtask

  always @(negedge aclk)
  begin
    if (out_valid === 1'b1)
    begin
      chk("sample_present", q.size() != 0, 1'b1);
      if (q.size() != 0)
        chk("samples", {out_a_i, out_a_q, out_b_i, out_b_q}, q.pop_front());
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  localparam logic [15:0] GA[6] = '{16'h2000, 16'hFFFF, 16'hA000, 16'h8000, 16'h3FFF, 16'h0000};
  localparam logic [15:0] GB[6] = '{16'hA000, 16'h7FFF, 16'h2000, 16'h2000, 16'h0000, 16'hE000};
  localparam logic [2:0]  MD[6] = '{3'h0, 3'h0, 3'h4, 3'h1, 3'h2, 3'h7};

  initial
  begin
    seed = 42;
    aresetn = 1'b0;
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_araddr, s_axi_arvalid, s_axi_rready, in_valid, tbl_index} = '0;
    {in_a_i, in_a_q, in_b_i, in_b_q} = '0;
    s_axi_wstrb = 4'hF;
    gain = '{default: 16'h0000};
    off = '{default: 16'h0000};
    mode = 3'h0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(negedge aclk);
    chk("shift_n_rst", limiter_shift_n, 6'h20);
    for (int i = 'hD2; i <= 'hF8; i++)
    begin
      rd(8'(i), rd_d, rsp);
      chk("reset_val", rd_d, (i == 'hD2) ? 32'h0000FFFF : 32'h00000000);
    end
    rd(8'h10, rd_d, rsp);
    chk("unmapped_rd", {rsp, rd_d}, {RESP_SLVERR, 32'h00000000});
    wr(8'h10, 16'h1234, rsp);
    chk("unmapped_wr", rsp, RESP_SLVERR);
    setr(IDX_TAB_SHIFT, 16'hFFF5);
    @(negedge aclk);
    chk("shift_n", limiter_shift_n, 6'h16);
    for (int k = 0; k < 32; k++)
    begin
      tv[k] = 16'($random(seed));
      setr(8'(IDX_TBL_FIRST + k), tv[k]);
    end
    for (int k = 0; k < 32; k++)
    begin
      @(posedge aclk);
      tbl_index <= 5'(k);
      @(posedge aclk);
      @(negedge aclk);
      chk("tbl_coef", tbl_coef, tv[k]);
    end
    // gains left at reset value: both ports must stay silent
    stream(10);
    for (int c = 0; c < 6; c++)
    begin
      gain[0] = GA[c];
      gain[1] = GB[c];
      mode = MD[c];
      foreach (off[j]) off[j] = (c == 1) ? 16'h7FFF : ((c == 0 || (c == 2 && j == 0)) ? 16'h0000 : 16'($random(seed)));
      setr(IDX_GAIN_A, gain[0]);
      setr(IDX_GAIN_B, gain[1]);
      foreach (off[j]) setr(8'(IDX_OFF_I0 + j), off[j]);
      setr(IDX_MODE, {13'h0000, mode});
      stream(48);
      if (c == 1)
      begin
        // the boosted pass must have clipped; writing one clears the sticky flag
        rd(IDX_STATUS, rd_d, rsp);
        chk("clip_flag", rd_d, 32'h00000001);
        wr(IDX_STATUS, 16'h0001, rsp);
        rd(IDX_STATUS, rd_d, rsp);
        chk("clip_clear", rd_d, 32'h00000000);
      end
    end
    chk("drained", q.size(), 0);
    chk("sink_count", n_taken, pushed);
    conclude();
  end
endmodule
